// file: hw/dsp_ctl_decode.sv
// Decode and execute of control, I/O move and accumulator instructions
`timescale 1ns/100ps
module dsp_ctl_decode
    import dsp_ctl_pkg::*;
(
    input  wire logic        clk_sys,      // system clock
    input  wire logic        rst_n,        // async reset
    input  wire logic        instr_valid,  // instruction word offered
    input  wire logic [15:0] instr,        // instruction word
    input  wire logic [15:0] instr2,       // second word of two-word forms
    input  wire logic        prog_ext,     // fetched from external program memory
    input  wire logic        data_ext,     // operand in external data memory
    input  wire logic [15:0] mem_rdata,    // operand read from data memory
    input  wire logic [15:0] treg,         // T register value
    output logic             busy,         // instruction in progress
    output logic [15:0]      pc,           // program counter
    output logic [31:0]      acc,          // accumulator
    output logic [15:0]      st0,          // status word zero
    output logic [15:0]      st1,          // status word one
    output logic             ext_flag_out, // external flag pin
    output logic [1:0]       block_cfg,    // on-chip block split
    output logic [7:0]       rpt_count,    // repeat counter
    output logic             mem_we,       // data memory write pulse
    output logic [6:0]       mem_addr,     // data memory address field
    output logic [15:0]      mem_wdata,    // data memory write data
    output logic             io_rd,        // port read pulse
    output logic             io_wr,        // port write pulse
    output logic [3:0]       io_port,      // port address
    output logic             illegal       // undefined opcode pulse
);
    state_type  state_q, state_d;
    kind_type   kind_q;
    logic [15:0] ir_q, ir2_q;
    logic [15:0] pc_q, st0_q, st1_q, wdata_q;
    logic [31:0] acc_q;
    logic [1:0]  cfg_q;
    logic [7:0]  rpt_q;
    logic [6:0]  addr_q;
    logic        xf_q, we_q, iord_q, iowr_q, ill_q, ext_q, dext_q, busy_q;
    logic [15:0] stack_q [STACK_DEPTH];
    logic [3:0]  wait_len;
    logic        wait_load, wait_busy;
    integer      si;

    // Opcode classifier used by the decode path
    function automatic kind_type classify(input logic [15:0] w);
        kind_type k;
        k = K_NONE;
        case (w[15:8])
            OP_BLOCK_MOVE_DATA_TO_DATA: k = K_BLOCK_MOVE_DATA_TO_DATA;
            OP_BLOCK_MOVE_PROG_TO_DATA: k = K_BLOCK_MOVE_PROG_TO_DATA;
            OP_DATA_WORD_MOVE: k = K_DATA_WORD_MOVE;
            OP_TEST_BIT_BY_T_REG: k = K_TEST_BIT_BY_T_REG;
            OP_LST0: k = K_LST0;
            OP_LOAD_STATUS_ONE: k = K_LOAD_STATUS_ONE;
            OP_SST0: k = K_SST0;
            OP_STORE_STATUS_ONE: k = K_STORE_STATUS_ONE;
            OP_POP_TO_DATA_MEMORY: k = K_POP_TO_DATA_MEMORY;
            OP_PUSH_FROM_DATA_MEMORY: k = K_PUSH_FROM_DATA_MEMORY;
            OP_RPT:  k = K_RPT;
            OP_REPEAT_BY_IMMEDIATE_COUNT: k = K_REPEAT_BY_IMMEDIATE_COUNT;
            OP_CE:
            begin
                if ({w[7:1], 1'b0} == LO_SERIAL_WORD_FORMAT_SELECT)      k = K_SERIAL_WORD_FORMAT_SELECT;
                else if (w[7:0] == LO_CLEAR_FRAME_SYNC_MODE)         k = K_CLEAR_FRAME_SYNC_MODE;
                else if (w[7:0] == LO_SET_FRAME_SYNC_MODE)         k = K_SET_FRAME_SYNC_MODE;
                else if (w[7:0] == LO_CLEAR_TRANSMIT_MODE)         k = K_CLEAR_TRANSMIT_MODE;
                else if (w[7:0] == LO_SET_TRANSMIT_MODE)         k = K_SET_TRANSMIT_MODE;
                else if (w[7:0] == LO_RXF)          k = K_RXF;
                else if (w[7:0] == LO_SXF)          k = K_SXF;
                else if ({w[7:2], 2'b00} == LO_ONCHIP_BLOCK_CONFIGURE) k = K_ONCHIP_BLOCK_CONFIGURE;
                else if (w[7:0] == LO_ABS)          k = K_ABS;
                else if (w[7:0] == LO_BLOCK_AS_DATA_MEMORY || w[7:0] == LO_BLOCK_AS_PROGRAM_MEMORY)
                    k = K_UNDEF;
            end
            default:
            begin
                if (w[15:12] == NIB_IN)       k = K_IN;
                else if (w[15:12] == NIB_OUT) k = K_OUT;
                else if (w[15:12] == NIB_BIT) k = K_BIT;
                else if (w[15:12] == NIB_ADD) k = K_ADDS;
            end
        endcase
        return k;
    endfunction

    kind_type  dec_kind;
    logic      two_word;
    logic [15:0] sel_bit_n;
    logic      test_bit;
    logic [31:0] opnd, sum, absv;
    logic [32:0] sum_wide;
    logic      add_ovf, abs_ovf;
    logic [15:0] st0_d, st1_d;
    logic [31:0] acc_d;

    assign dec_kind = classify(instr);
    assign two_word = (kind_q == K_BLOCK_MOVE_DATA_TO_DATA) || (kind_q == K_BLOCK_MOVE_PROG_TO_DATA);
    // Bit field counts from the MSB
    assign sel_bit_n = (kind_q == K_TEST_BIT_BY_T_REG) ? treg : {12'h000, ir_q[11:8]};
    assign test_bit  = mem_rdata[4'hF - sel_bit_n[3:0]];
    // Operand extension and shift
    assign opnd = (st1_q[ST1_SXM] ? {{16{mem_rdata[15]}}, mem_rdata}
                                  : {16'h0000, mem_rdata}) << ir_q[11:8];
    assign sum_wide = {1'b0, acc_q} + {1'b0, opnd};
    assign sum      = sum_wide[31:0];
    assign add_ovf  = (acc_q[31] == opnd[31]) && (sum[31] != acc_q[31]);
    assign abs_ovf  = (acc_q == ACC_MIN);
    assign absv     = acc_q[31] ? (32'h0 - acc_q) : acc_q;
    // Wait length: program wait on external fetch, data or I/O wait after
    assign wait_len = (kind_q == K_IN || kind_q == K_OUT) ? I_WAIT_W :
                      dext_q ? D_WAIT_W : 4'h0;
    assign wait_load = (state_q == S_FETCH && instr_valid && prog_ext && P_WAIT_W != 4'h0) ||
                       (state_q == S_EXT && !wait_busy && wait_len != 4'h0);
    // Entering the wait state is itself one wait cycle, so load one less
    logic [3:0] wait_cnt;
    assign wait_cnt = ((state_q == S_FETCH) ? P_WAIT_W : wait_len) - 4'h1;

    wait_counter i_wait_counter (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .load    (wait_load),
        .count   (wait_cnt),
        .busy    (wait_busy)
    );

    // Sequencer: fetch, program wait, operand cycle, data or I/O wait, execute
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            S_FETCH: if (instr_valid)
                         state_d = (prog_ext && P_WAIT_W != 4'h0) ? S_WAIT : S_EXT;
            S_WAIT:  if (!wait_busy) state_d = S_EXT;
            S_EXT:   state_d = (wait_len != 4'h0) ? S_REP : S_EXEC;
            S_REP:   if (!wait_busy) state_d = S_EXEC;
            S_EXEC:  state_d = S_FETCH;
            default: state_d = S_FETCH;
        endcase
    end

    // Status and accumulator next values
    always_comb
    begin
        st0_d = st0_q;
        st1_d = st1_q;
        acc_d = acc_q;
        case (kind_q)
            K_SERIAL_WORD_FORMAT_SELECT: st1_d[ST1_FO]  = ir_q[0];
            K_CLEAR_FRAME_SYNC_MODE: st1_d[ST1_FSM] = 1'b0;
            K_SET_FRAME_SYNC_MODE: st1_d[ST1_FSM] = 1'b1;
            K_CLEAR_TRANSMIT_MODE: st1_d[ST1_TXM] = 1'b0;
            K_SET_TRANSMIT_MODE: st1_d[ST1_TXM] = 1'b1;
            K_RXF:  st1_d[ST1_XF]  = 1'b0;
            K_SXF:  st1_d[ST1_XF]  = 1'b1;
            K_BIT, K_TEST_BIT_BY_T_REG: st1_d[ST1_TC] = test_bit;
            K_LST0: st0_d = mem_rdata;
            K_LOAD_STATUS_ONE: st1_d = mem_rdata;
            K_ABS:
            begin
                st1_d[ST1_C] = 1'b0;
                if (abs_ovf)
                begin
                    st0_d[ST0_OV] = 1'b1;
                    acc_d = st0_q[ST0_OVM] ? ACC_MAX : ACC_MIN;
                end
                else
                    acc_d = absv;
            end
            K_ADDS:
            begin
                st1_d[ST1_C] = sum_wide[32];
                if (add_ovf)
                begin
                    st0_d[ST0_OV] = 1'b1;
                    acc_d = !st0_q[ST0_OVM] ? sum :
                            (acc_q[31] ? ACC_MIN : ACC_MAX);
                end
                else
                    acc_d = sum;
            end
            default: ;
        endcase
    end

    logic exec;
    assign exec = (state_q == S_EXEC);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= S_FETCH;
            kind_q  <= K_NONE;
            ir_q    <= 16'h0000;
            ir2_q   <= 16'h0000;
            ext_q   <= 1'b0;
            dext_q  <= 1'b0;
            busy_q  <= 1'b0;
            addr_q  <= 7'h00;
        end
        else
        begin
            state_q <= state_d;
            busy_q  <= (state_d != S_FETCH);
            if (state_q == S_FETCH && instr_valid)
            begin
                addr_q <= (dec_kind == K_BLOCK_MOVE_DATA_TO_DATA || dec_kind == K_BLOCK_MOVE_PROG_TO_DATA) ? instr2[6:0] : instr[6:0];
                kind_q <= dec_kind;
                ir_q   <= instr;
                ir2_q  <= instr2;
                ext_q  <= prog_ext;
                dext_q <= data_ext;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st0_q <= ST0_RESET;
            st1_q <= ST1_RESET;
            acc_q <= ACC_RESET;
            pc_q  <= PC_RESET;
        end
        else if (exec)
        begin
            st0_q <= st0_d;
            st1_q <= st1_d;
            acc_q <= acc_d;
            pc_q  <= pc_q + (two_word ? 16'h0002 : 16'h0001);
        end
    end

    // Stack, repeat counter, block split, flag pin and memory strobes
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (si = 0; si < STACK_DEPTH; si = si + 1)
                stack_q[si] <= 16'h0000;
            rpt_q   <= 8'h00;
            cfg_q   <= 2'b00;
            xf_q    <= 1'b0;
            we_q    <= 1'b0;
            iord_q  <= 1'b0;
            iowr_q  <= 1'b0;
            ill_q   <= 1'b0;
            wdata_q <= 16'h0000;
        end
        else
        begin
            we_q   <= exec && (kind_q == K_SST0 || kind_q == K_STORE_STATUS_ONE ||
                               kind_q == K_POP_TO_DATA_MEMORY || kind_q == K_DATA_WORD_MOVE ||
                               kind_q == K_IN   || kind_q == K_BLOCK_MOVE_DATA_TO_DATA ||
                               kind_q == K_BLOCK_MOVE_PROG_TO_DATA);
            iord_q <= exec && (kind_q == K_IN);
            iowr_q <= exec && (kind_q == K_OUT);
            ill_q  <= exec && (kind_q == K_UNDEF);
            if (exec)
            begin
                case (kind_q)
                    K_SST0: wdata_q <= st0_q;
                    K_STORE_STATUS_ONE: wdata_q <= st1_q;
                    K_POP_TO_DATA_MEMORY:
                    begin
                        wdata_q <= stack_q[0];
                        for (si = 0; si < STACK_DEPTH - 1; si = si + 1)
                            stack_q[si] <= stack_q[si + 1];
                    end
                    K_PUSH_FROM_DATA_MEMORY:
                    begin
                        stack_q[0] <= mem_rdata;
                        for (si = 1; si < STACK_DEPTH; si = si + 1)
                            stack_q[si] <= stack_q[si - 1];
                    end
                    K_REPEAT_BY_IMMEDIATE_COUNT: rpt_q <= ir_q[7:0];
                    K_RPT:  rpt_q <= mem_rdata[7:0];
                    K_ONCHIP_BLOCK_CONFIGURE: cfg_q <= ir_q[1:0];
                    K_RXF, K_SXF, K_LOAD_STATUS_ONE:
                        xf_q <= st1_d[ST1_XF];
                    K_BLOCK_MOVE_DATA_TO_DATA, K_BLOCK_MOVE_PROG_TO_DATA, K_DATA_WORD_MOVE, K_IN: wdata_q <= mem_rdata;
                    default: ;
                endcase
            end
        end
    end

    assign busy         = busy_q;
    assign pc           = pc_q;
    assign acc          = acc_q;
    assign st0          = st0_q;
    assign st1          = st1_q;
    assign ext_flag_out = xf_q;
    assign block_cfg    = cfg_q;
    assign rpt_count    = rpt_q;
    assign mem_we       = we_q;
    assign mem_addr     = addr_q;
    assign mem_wdata    = wdata_q;
    assign io_rd        = iord_q;
    assign io_wr        = iowr_q;
    assign io_port      = ir_q[11:8];
    assign illegal      = ill_q;

    chk_flag_pin_tracks: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ext_flag_out == st1_q[ST1_XF])
        else $error("flag pin differs from status bit");
    chk_abs_clears_carry: assert property (@(posedge clk_sys) disable iff (!rst_n)
        exec && kind_q == K_ABS |=> !st1_q[ST1_C])
        else $error("carry left set after absolute value");
    chk_abs_min_sat: assert property (@(posedge clk_sys) disable iff (!rst_n)
        exec && kind_q == K_ABS && acc_q == ACC_MIN && st0_q[ST0_OVM]
        |=> acc_q == ACC_MAX && st0_q[ST0_OV])
        else $error("most negative value not saturated");
    chk_abs_nonneg: assert property (@(posedge clk_sys) disable iff (!rst_n)
        exec && kind_q == K_ABS && !acc_q[31] |=> $stable(acc_q))
        else $error("non-negative accumulator changed");
    chk_pc_advance: assert property (@(posedge clk_sys) disable iff (!rst_n)
        exec |=> pc_q == $past(pc_q) + (($past(two_word)) ? 16'h0002 : 16'h0001))
        else $error("program counter step wrong");
    chk_repeat_by_immediate_count_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
        exec && kind_q == K_REPEAT_BY_IMMEDIATE_COUNT |=> rpt_q == $past(ir_q[7:0]))
        else $error("repeat counter not loaded");
    chk_undef_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        exec && kind_q == K_UNDEF |=> illegal ##1 !illegal)
        else $error("undefined opcode not flagged once");
    chk_fetch_ext_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == S_FETCH && instr_valid && prog_ext && P_WAIT_W == 4'h0
        |=> state_q == S_EXT)
        else $error("zero-wait external fetch stalled");
endmodule

// file: pkg/dsp_ctl_pkg.sv
// Constants and types for the control, I/O move and accumulator decode block
package dsp_ctl_pkg;
    // Clock and wait-state timing
    localparam int CLK_PERIOD_NS   = 50;
    localparam int T_AC_NS         = 40;   // zero-wait access time, plain default
    localparam int T_MEM_PROG_NS   = 40;
    localparam int T_MEM_DATA_NS   = 40;
    localparam int T_MEM_IO_NS     = 140;
    // Smallest k with T_mem <= k*T_p + T_ac
    localparam int P_WAIT = (T_MEM_PROG_NS <= T_AC_NS) ? 0 :
        (T_MEM_PROG_NS - T_AC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int D_WAIT = (T_MEM_DATA_NS <= T_AC_NS) ? 0 :
        (T_MEM_DATA_NS - T_AC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int I_WAIT = (T_MEM_IO_NS <= T_AC_NS) ? 0 :
        (T_MEM_IO_NS - T_AC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] P_WAIT_W = P_WAIT[3:0];
    localparam logic [3:0] D_WAIT_W = D_WAIT[3:0];
    localparam logic [3:0] I_WAIT_W = I_WAIT[3:0];

    // Opcode upper bytes and upper nibbles
    localparam logic [7:0] OP_BLOCK_MOVE_DATA_TO_DATA   = 8'hFD;
    localparam logic [7:0] OP_BLOCK_MOVE_PROG_TO_DATA   = 8'hFC;
    localparam logic [7:0] OP_DATA_WORD_MOVE   = 8'h56;
    localparam logic [7:0] OP_TEST_BIT_BY_T_REG   = 8'h57;
    localparam logic [7:0] OP_LST0   = 8'h50;
    localparam logic [7:0] OP_LOAD_STATUS_ONE   = 8'h51;
    localparam logic [7:0] OP_SST0   = 8'h78;
    localparam logic [7:0] OP_STORE_STATUS_ONE   = 8'h79;
    localparam logic [7:0] OP_POP_TO_DATA_MEMORY   = 8'h7A;
    localparam logic [7:0] OP_PUSH_FROM_DATA_MEMORY   = 8'h54;
    localparam logic [7:0] OP_RPT    = 8'h4B;
    localparam logic [7:0] OP_REPEAT_BY_IMMEDIATE_COUNT   = 8'hCB;
    localparam logic [7:0] OP_CE     = 8'hCE;
    localparam logic [3:0] NIB_IN    = 4'h8;
    localparam logic [3:0] NIB_OUT   = 4'hE;
    localparam logic [3:0] NIB_BIT   = 4'h9;
    localparam logic [3:0] NIB_ADD   = 4'h0;
    // Low bytes under CE
    localparam logic [7:0] LO_SERIAL_WORD_FORMAT_SELECT   = 8'h0E;  // mask FE
    localparam logic [7:0] LO_CLEAR_FRAME_SYNC_MODE   = 8'h36;
    localparam logic [7:0] LO_SET_FRAME_SYNC_MODE   = 8'h37;
    localparam logic [7:0] LO_CLEAR_TRANSMIT_MODE   = 8'h20;
    localparam logic [7:0] LO_SET_TRANSMIT_MODE   = 8'h21;
    localparam logic [7:0] LO_RXF    = 8'h0C;
    localparam logic [7:0] LO_SXF    = 8'h0D;
    localparam logic [7:0] LO_BLOCK_AS_DATA_MEMORY   = 8'h04;
    localparam logic [7:0] LO_BLOCK_AS_PROGRAM_MEMORY   = 8'h05;
    localparam logic [7:0] LO_ONCHIP_BLOCK_CONFIGURE   = 8'h3C;  // mask FC
    localparam logic [7:0] LO_ABS    = 8'h1B;

    // Status field positions in the two status words
    localparam int ST0_OV   = 12;
    localparam int ST0_OVM  = 11;
    localparam int ST1_TC   = 11;
    localparam int ST1_SXM  = 10;
    localparam int ST1_C    = 9;
    localparam int ST1_XF   = 4;
    localparam int ST1_FO   = 3;
    localparam int ST1_TXM  = 2;
    localparam int ST1_FSM  = 5;
    localparam logic [15:0] ST0_RESET = 16'h0000;
    localparam logic [15:0] ST1_RESET = 16'h0000;
    localparam logic [31:0] ACC_MIN   = 32'h80000000;
    localparam logic [31:0] ACC_MAX   = 32'h7FFFFFFF;
    localparam logic [31:0] ACC_RESET = 32'h00000000;
    localparam logic [15:0] PC_RESET  = 16'h0000;
    localparam int STACK_DEPTH = 8;

    typedef enum logic [2:0] {
        S_FETCH, S_EXT, S_WAIT, S_EXEC, S_REP
    } state_type;

    typedef enum logic [4:0] {
        K_NONE, K_BLOCK_MOVE_DATA_TO_DATA, K_BLOCK_MOVE_PROG_TO_DATA, K_DATA_WORD_MOVE, K_SERIAL_WORD_FORMAT_SELECT, K_IN, K_OUT, K_CLEAR_FRAME_SYNC_MODE, K_SET_FRAME_SYNC_MODE,
        K_CLEAR_TRANSMIT_MODE, K_SET_TRANSMIT_MODE, K_RXF, K_SXF, K_BIT, K_TEST_BIT_BY_T_REG, K_ONCHIP_BLOCK_CONFIGURE, K_LST0, K_LOAD_STATUS_ONE,
        K_SST0, K_STORE_STATUS_ONE, K_POP_TO_DATA_MEMORY, K_PUSH_FROM_DATA_MEMORY, K_RPT, K_REPEAT_BY_IMMEDIATE_COUNT, K_ABS, K_ADDS, K_UNDEF
    } kind_type;
endpackage

// file: hw/wait_counter.sv
// Down-counter that holds an access for a number of wait cycles
`timescale 1ns/100ps
module wait_counter
    import dsp_ctl_pkg::*;
(
    input  wire logic       clk_sys,  // system clock
    input  wire logic       rst_n,    // async reset
    input  wire logic       load,     // start a wait period
    input  wire logic [3:0] count,    // cycles to wait
    output logic            busy      // wait in progress
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    assign cnt_d = load ? count : ((cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0);
    assign busy  = (cnt_q != 4'h0);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= 4'h0;
        else
            cnt_q <= cnt_d;
    end
endmodule

// file: bench/ext_mem_model.sv
// External data memory model at the far side of the decode block
`timescale 1ns/100ps
module ext_mem_model (
    input  wire logic        clk_sys,   // system clock
    input  wire logic        busy,      // block busy
    input  wire logic [15:0] instr,     // offered word
    input  wire logic        mem_we,    // write pulse
    input  wire logic [6:0]  mem_addr,  // address field
    input  wire logic [15:0] mem_wdata, // write data
    output logic      [15:0] mem_rdata, // read data
    output int               wr_count   // writes seen
);
    logic [15:0] mem [128];
    // Offered word addresses the operand until the block latches it
    wire  [6:0]  rd_addr = busy ? mem_addr : instr[6:0];
    assign mem_rdata = mem[rd_addr];
    initial wr_count = 0;
    initial foreach (mem[i]) mem[i] = 16'h0000;
    always @(posedge clk_sys) if (mem_we) mem[mem_addr] <= mem_wdata;
    always @(posedge clk_sys) wr_count <= wr_count + int'(mem_we);
endmodule

// file: bench/dsp_ctl_decode_tb.sv
// Self-checking bench for the control and accumulator decode block
`timescale 1ns/100ps
module dsp_ctl_decode_tb;
    import dsp_ctl_pkg::*;
    logic        clk_sys = 1'h0, rst_n = 1'h0, instr_valid = 1'h0;
    logic        prog_ext = 1'h0, data_ext = 1'h0, ill_seen;
    logic [1:0]  io_seen;
    logic [15:0] instr = 16'h0000, instr2 = 16'h0000, treg = 16'h000F;
    logic [3:0]  port_seen;
    wire  [15:0] mem_rdata, pc, st0, st1, mem_wdata;
    wire  [31:0] acc;
    wire  [7:0]  rpt_count;
    wire  [6:0]  mem_addr;
    wire  [3:0]  io_port;
    wire  [1:0]  block_cfg;
    wire         busy, ext_flag_out, mem_we, io_rd, io_wr, illegal;
    int          wr_count, num_errors = 0, checked = 0, k;
    logic [7:0]  lo_tab [8] = '{LO_SXF, LO_RXF, LO_SET_FRAME_SYNC_MODE, LO_CLEAR_FRAME_SYNC_MODE, LO_SET_TRANSMIT_MODE, LO_CLEAR_TRANSMIT_MODE,
                                LO_SERIAL_WORD_FORMAT_SELECT | 8'h01, LO_SERIAL_WORD_FORMAT_SELECT};
    int          pos_tab [8] = '{ST1_XF, ST1_XF, ST1_FSM, ST1_FSM, ST1_TXM, ST1_TXM,
                                 ST1_FO, ST1_FO};
    always #25 clk_sys = ~clk_sys;
    dsp_ctl_decode i_dsp_ctl_decode (.clk_sys, .rst_n, .instr_valid, .instr, .instr2,
        .prog_ext, .data_ext, .mem_rdata, .treg, .busy, .pc, .acc, .st0, .st1,
        .ext_flag_out, .block_cfg, .rpt_count, .mem_we, .mem_addr, .mem_wdata, .io_rd,
        .io_wr, .io_port, .illegal);
    ext_mem_model i_ext_mem_model (.clk_sys, .busy, .instr, .mem_we, .mem_addr,
        .mem_wdata, .mem_rdata, .wr_count);
    task automatic summarize();
        $display("Checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_cnt(input string what, input int exp, input int got);
        checked++;
        if (got != exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // One instruction: offer, take, count busy cycles, capture pulses
    task automatic run(input logic [15:0] w, input logic [15:0] w2 = 16'h0000,
                       input logic pe = 1'h0, input logic de = 1'h0,
                       input int words = 1, input int extra = 0);
        logic [15:0] pc0;
        int          n;
        pc0 = pc;
        @(posedge clk_sys);
        instr_valid <= 1'h1;
        instr <= w;
        instr2 <= w2;
        prog_ext <= pe;
        data_ext <= de;
        @(posedge clk_sys);
        instr_valid <= 1'h0;
        n = 0;
        #1;
        while (busy === 1'h1 && n < 60)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        io_seen = {io_rd, io_wr};
        ill_seen = illegal;
        port_seen = io_port;
        chk_cnt("cycles", 2 + extra + (pe ? P_WAIT : 0) + (de ? D_WAIT : 0), n);
        chk_val("pc", pc0 + words, pc);
        if (n >= 60)
            summarize();
        @(posedge clk_sys);
        #1;
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        chk_val("acc rst", ACC_RESET, acc);
        chk_val("st1 rst", ST1_RESET, st1);
        rst_n <= 1'h1;
        for (k = 0; k < 8; k++)
        begin
            run({OP_CE, lo_tab[k]}, 16'h0000, k[0]);
            chk_val("st1 mode", k[0] == 1'h0, st1[pos_tab[k]]);
            chk_val("xf pin", k == 0, ext_flag_out);
        end
        for (k = 0; k < 4; k++)
        begin
            run({OP_CE, LO_ONCHIP_BLOCK_CONFIGURE | 8'(k)});
            chk_val("block cfg", k, block_cfg);
        end
        run({OP_CE, LO_BLOCK_AS_DATA_MEMORY});
        chk_val("cnf data", 1, ill_seen);
        run({OP_CE, LO_BLOCK_AS_PROGRAM_MEMORY});
        chk_val("cnf prog", 1, ill_seen);
        i_ext_mem_model.mem[10] = 16'h8000;
        i_ext_mem_model.mem[11] = 16'h0001 << ST1_SXM;
        i_ext_mem_model.mem[12] = 16'h0001 << ST0_OVM;
        i_ext_mem_model.mem[20] = 16'h0001;
        i_ext_mem_model.mem[21] = 16'h003C;
        i_ext_mem_model.mem[22] = 16'h1234;
        run({OP_LOAD_STATUS_ONE, 8'h0B});
        chk_val("sxm", 1, st1[ST1_SXM]);
        run({NIB_ADD, 4'hF, 8'h0A});
        chk_val("add ext", 32'hC0000000, acc);
        run({NIB_ADD, 4'hF, 8'h0A}, 16'h0000, 1'h0, 1'h1);
        chk_val("add carry", 1, st1[ST1_C]);
        run({OP_CE, LO_ABS});
        chk_val("abs min", ACC_MIN, acc);
        chk_val("abs ov", 1, st0[ST0_OV]);
        chk_val("abs c", 0, st1[ST1_C]);
        run({OP_LST0, 8'h0C});
        run({OP_CE, LO_ABS});
        chk_val("abs sat", ACC_MAX, acc);
        run({NIB_ADD, 4'hF, 8'h0A});
        run({OP_CE, LO_ABS});
        chk_val("abs pos", 32'h3FFFFFFF, acc);
        run({OP_STORE_STATUS_ONE, 8'h0D}, 16'h0000, 1'h0, 1'h1);
        chk_val("store_status_one", 1, i_ext_mem_model.mem[13][ST1_SXM]);
        run({OP_LOAD_STATUS_ONE, 8'h00});
        run({NIB_ADD, 4'h4, 8'h0A});
        chk_val("add zero", 32'h4007FFFF, acc);
        run({NIB_BIT, 4'hF, 8'h14});
        chk_val("bit lsb", 1, st1[ST1_TC]);
        run({NIB_BIT, 4'hE, 8'h14});
        chk_val("bit one", 0, st1[ST1_TC]);
        run({OP_TEST_BIT_BY_T_REG, 8'h14});
        chk_val("bit treg", 1, st1[ST1_TC]);
        run({OP_REPEAT_BY_IMMEDIATE_COUNT, 8'hA5});
        chk_val("rpt imm", 8'hA5, rpt_count);
        run({OP_RPT, 8'h15});
        chk_val("rpt mem", 8'h3C, rpt_count);
        run({OP_PUSH_FROM_DATA_MEMORY, 8'h16});
        run({OP_POP_TO_DATA_MEMORY, 8'h17});
        chk_val("pop", 16'h1234, i_ext_mem_model.mem[23]);
        k = wr_count;
        run({OP_DATA_WORD_MOVE, 8'h16});
        run({OP_BLOCK_MOVE_DATA_TO_DATA, 8'h16}, 16'h001E, 1'h0, 1'h0, 2);
        run({OP_BLOCK_MOVE_PROG_TO_DATA, 8'h16}, 16'h001F, 1'h0, 1'h0, 2);
        chk_cnt("moves", k + 3, wr_count);
        run({NIB_IN, 4'h5, 8'h19}, 16'h0000, 1'h0, 1'h0, 1, I_WAIT);
        chk_val("in port", 4'h5, port_seen);
        chk_val("in pulse", 2'h2, io_seen);
        run({NIB_OUT, 4'hA, 8'h19}, 16'h0000, 1'h0, 1'h0, 1, I_WAIT);
        chk_val("out port", 4'hA, port_seen);
        chk_val("out pulse", 2'h1, io_seen);
        summarize();
    end
endmodule
